/* hdl/rtcic_pkg.sv */
// Shared constants and types of the real-time clock interrupt control block
package rtcic_pkg;

  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam logic [7:0] RTCIC_FLAG_OFS = 8'h0E;
  localparam logic [7:0] RTCIC_CTRL_OFS = 8'h0F;
  localparam logic [7:0] RTCIC_ISTAT_OFS = 8'h10;
  localparam logic [7:0] RTCIC_IMASK_OFS = 8'h11;

  // ----------------------------------------
  // Control register fields
  // ----------------------------------------
  localparam int RTCIC_CSEL_HI_BIT = 7;
  localparam int RTCIC_CSEL_LO_BIT = 6;
  localparam int RTCIC_UIE_BIT = 5;
  localparam int RTCIC_TIE_BIT = 4;
  localparam int RTCIC_AIE_BIT = 3;
  localparam int RTCIC_EIE_BIT = 2;
  localparam int RTCIC_RST_BIT = 0;
  localparam logic [1:0] RTCIC_CSEL_RESET = 2'h1;

  // ----------------------------------------
  // Flag register fields
  // ----------------------------------------
  localparam int RTCIC_UF_BIT = 5;
  localparam int RTCIC_TF_BIT = 4;
  localparam int RTCIC_AF_BIT = 3;
  localparam int RTCIC_EVF_BIT = 2;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam longint RTCIC_CLK_KHZ = 64'h1E848;
  localparam longint RTCIC_RELEASE_US = 64'h1E78;
  localparam longint RTCIC_COMP0_MS = 64'h1F4;
  localparam longint RTCIC_COMP1_MS = 64'h7D0;
  localparam longint RTCIC_COMP2_MS = 64'h2710;
  localparam longint RTCIC_COMP3_MS = 64'h7530;
  // Longest release time rounds down
  localparam logic [19:0] RTCIC_RELEASE_CYC = 20'((RTCIC_RELEASE_US * RTCIC_CLK_KHZ) / 64'h3E8);
  localparam logic [31:0] RTCIC_COMP0_CYC = 32'(RTCIC_COMP0_MS * RTCIC_CLK_KHZ);
  localparam logic [31:0] RTCIC_COMP1_CYC = 32'(RTCIC_COMP1_MS * RTCIC_CLK_KHZ);
  localparam logic [31:0] RTCIC_COMP2_CYC = 32'(RTCIC_COMP2_MS * RTCIC_CLK_KHZ);
  localparam logic [31:0] RTCIC_COMP3_CYC = 32'(RTCIC_COMP3_MS * RTCIC_CLK_KHZ);

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef struct packed {
    logic update;
    logic timer;
    logic alarm;
    logic extEvt;
  } rtcic_evt_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } rtcic_bus_t;

  typedef enum logic [1:0] {
    RTCIC_RUN,
    RTCIC_HALT
  } rtcic_clk_state_t;

endpackage

/* hdl/rtcic_release_timer.sv */
// Timed hold of one interrupt source with automatic release
`timescale 1ns/10ps
`default_nettype none
module rtcic_release_timer
  import rtcic_pkg::*;
#(
  parameter logic [19:0] HOLD_CYC = RTCIC_RELEASE_CYC
)
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic start,
  input wire logic cancel,
  output logic active
);

  logic [19:0] cnt_r;

  // ----------------------------------------
  // Hold counter
  // ----------------------------------------
  // Cancel wins so a disable in the event cycle leaves the pin released
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt_r <= 20'h00000;
    end
    else if (cancel)
    begin
      cnt_r <= 20'h00000;
    end
    else if (start)
    begin
      cnt_r <= HOLD_CYC;
    end
    else if (cnt_r != 20'h00000)
    begin
      cnt_r <= cnt_r - 20'h00001;
    end
  end

  assign active = (cnt_r != 20'h00000);

endmodule
`default_nettype wire

/* hdl/rtcic_top.sv */
// Interrupt and compensation control of a real-time clock
//
// Summary of operation
// [RL1] Interval field picks 0.5, 2, 10, 30 s
// [RL2] Update flag rise with enable pulls pin low
// [RL3] Update low released automatically after 7.8 ms
// [RL4] Clearing update enable cancels update low
// [RL5] Timer flag rise with enable pulls pin low
// [RL6] Timer low released within 7.8 ms
// [RL7] Clearing timer enable cancels timer low
// [RL8] Alarm low held until alarm flag cleared
// [RL9] Clearing alarm enable cancels alarm low
// [RL10] Pin low is OR of qualified requests
// [RL11] Flags still set with all enables off
// [RL12] Event flag rise with enable pulls pin low
// [RL13] Reset bit clears sub-second, halts clock
// [RL14] Chip enable low releases the halt
// [RL15] Flags set on event, kept until zeroed
// [RL16] Event low held until flag or enable cleared
`timescale 1ns/10ps
`default_nettype none
module rtcic_top
  import rtcic_pkg::*;
#(
  parameter logic [19:0] RELEASE_CYC = RTCIC_RELEASE_CYC,
  parameter logic [31:0] COMP0_CYC = RTCIC_COMP0_CYC,
  parameter logic [31:0] COMP1_CYC = RTCIC_COMP1_CYC,
  parameter logic [31:0] COMP2_CYC = RTCIC_COMP2_CYC,
  parameter logic [31:0] COMP3_CYC = RTCIC_COMP3_CYC
)
(
  input wire logic clk,
  input wire logic rst_n,
  input wire rtcic_bus_t bus,
  output logic [7:0] rdata,
  input wire rtcic_evt_t evt,
  input wire logic chipEnable,
  output logic intPinO,
  output logic intPinOeN,
  output logic [1:0] compIntervalSel,
  output logic compTick,
  output logic subSecClear,
  output logic clockHalt,
  output logic irq
);

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  logic [1:0] cselR;
  logic updateIrqEnable;
  logic timerIrqEnable;
  logic alarmIrqEnable;
  logic eventIrqEnable;
  rtcic_evt_t flag_r;
  rtcic_evt_t flag_nxt;
  rtcic_evt_t flagRise;
  rtcic_evt_t flagFall;
  rtcic_evt_t istat_r;
  rtcic_evt_t imask_r;
  logic alarmHold_r;
  logic eventHold_r;
  logic [1:0] timedStart;
  logic [1:0] timedCancel;
  logic [1:0] timedActive;
  logic ceMeta_r;
  logic ceSync_r;
  logic [31:0] compCnt_r;
  logic [31:0] compLimit;
  logic wrCtrl;
  logic wrFlag;
  rtcic_clk_state_t clkState_r;

  assign wrCtrl = bus.wr && (bus.addr == RTCIC_CTRL_OFS);
  assign wrFlag = bus.wr && (bus.addr == RTCIC_FLAG_OFS);
  assign compIntervalSel = cselR; // RL1

  // ----------------------------------------
  // Control register
  // ----------------------------------------
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cselR <= RTCIC_CSEL_RESET;
      updateIrqEnable <= 1'b0;
      timerIrqEnable <= 1'b0;
      alarmIrqEnable <= 1'b0;
      eventIrqEnable <= 1'b0;
    end
    else if (wrCtrl)
    begin
      cselR <= bus.wdata[RTCIC_CSEL_HI_BIT:RTCIC_CSEL_LO_BIT];
      updateIrqEnable <= bus.wdata[RTCIC_UIE_BIT];
      timerIrqEnable <= bus.wdata[RTCIC_TIE_BIT];
      alarmIrqEnable <= bus.wdata[RTCIC_AIE_BIT];
      eventIrqEnable <= bus.wdata[RTCIC_EIE_BIT];
    end
  end

  // ----------------------------------------
  // Flags
  // ----------------------------------------
  // Flags set regardless of enables; set beats a same-cycle clear
  always_comb
  begin
    flag_nxt = flag_r;
    if (wrFlag)
    begin
      flag_nxt.update = flag_r.update & bus.wdata[RTCIC_UF_BIT];
      flag_nxt.timer = flag_r.timer & bus.wdata[RTCIC_TF_BIT];
      flag_nxt.alarm = flag_r.alarm & bus.wdata[RTCIC_AF_BIT];
      flag_nxt.extEvt = flag_r.extEvt & bus.wdata[RTCIC_EVF_BIT];
    end
    flag_nxt = flag_nxt | evt; // RL11 RL15
  end

  assign flagRise = evt & ~flag_r;
  assign flagFall = flag_r & ~flag_nxt;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      flag_r <= '0;
    end
    else
    begin
      flag_r <= flag_nxt; // RL15
    end
  end

  // ----------------------------------------
  // Interrupt pin sources
  // ----------------------------------------
  // A source fires only on a 0-to-1 flag change seen with its enable set
  assign timedStart[0] = flagRise.update && updateIrqEnable; // RL2
  assign timedStart[1] = flagRise.timer && timerIrqEnable; // RL5
  assign timedCancel[0] = !updateIrqEnable || flagFall.update; // RL4
  assign timedCancel[1] = !timerIrqEnable || flagFall.timer; // RL7

  generate
    for (genvar gi = 0; gi < 2; gi++)
    begin : gTimed
      rtcic_release_timer #(
        .HOLD_CYC(RELEASE_CYC)
      ) uRel (
        .clk(clk),
        .rst_n(rst_n),
        .start(timedStart[gi]), // RL3 RL6
        .cancel(timedCancel[gi]),
        .active(timedActive[gi])
      );
    end
  endgenerate

  // Alarm holds with no timed release
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      alarmHold_r <= 1'b0;
    end
    else if (!alarmIrqEnable || flagFall.alarm)
    begin
      alarmHold_r <= 1'b0; // RL8 RL9
    end
    else if (flagRise.alarm)
    begin
      alarmHold_r <= 1'b1; // RL8
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      eventHold_r <= 1'b0;
    end
    else if (!eventIrqEnable || flagFall.extEvt)
    begin
      eventHold_r <= 1'b0; // RL16
    end
    else if (flagRise.extEvt)
    begin
      eventHold_r <= 1'b1; // RL12
    end
  end

  // Open drain: data is always low, enable decides
  assign intPinO = 1'b0;
  assign intPinOeN = !(|timedActive || alarmHold_r || eventHold_r); // RL10

  // ----------------------------------------
  // Reset bit and halt
  // ----------------------------------------
  // Chip enable is a pin, so it is synchronised before use
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ceMeta_r <= 1'b1;
      ceSync_r <= 1'b1;
    end
    else
    begin
      ceMeta_r <= chipEnable;
      ceSync_r <= ceMeta_r;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      clkState_r <= RTCIC_RUN;
    end
    else
    begin
      case (clkState_r)
        RTCIC_RUN:
        begin
          if (wrCtrl && bus.wdata[RTCIC_RST_BIT])
          begin
            clkState_r <= RTCIC_HALT; // RL13
          end
        end
        RTCIC_HALT:
        begin
          if (!ceSync_r && !(wrCtrl && bus.wdata[RTCIC_RST_BIT]))
          begin
            clkState_r <= RTCIC_RUN; // RL14
          end
        end
        default:
        begin
          clkState_r <= RTCIC_RUN;
        end
      endcase
    end
  end

  // Sub-second chain is held clear for as long as the clock is halted
  assign clockHalt = (clkState_r == RTCIC_HALT); // RL13
  assign subSecClear = clockHalt; // RL13

  // ----------------------------------------
  // Compensation interval
  // ----------------------------------------
  always_comb
  begin
    case (cselR)
      2'h0: compLimit = COMP0_CYC; // RL1
      2'h1: compLimit = COMP1_CYC; // RL1
      2'h2: compLimit = COMP2_CYC; // RL1
      default: compLimit = COMP3_CYC; // RL1
    endcase
  end

  // Counts up so a new selection takes effect without a stale reload
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      compCnt_r <= 32'h00000000;
      compTick <= 1'b0;
    end
    else if (compCnt_r + 32'h00000001 >= compLimit)
    begin
      compCnt_r <= 32'h00000000;
      compTick <= 1'b1; // RL1
    end
    else
    begin
      compCnt_r <= compCnt_r + 32'h00000001;
      compTick <= 1'b0;
    end
  end

  // ----------------------------------------
  // Sticky status and mask
  // ----------------------------------------
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      istat_r <= '0;
    end
    else if (bus.wr && bus.addr == RTCIC_ISTAT_OFS)
    begin
      istat_r <= (istat_r & ~rtcic_evt_t'(bus.wdata[3:0])) | evt;
    end
    else
    begin
      istat_r <= istat_r | evt;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      imask_r <= '0;
    end
    else if (bus.wr && bus.addr == RTCIC_IMASK_OFS)
    begin
      imask_r <= rtcic_evt_t'(bus.wdata[3:0]);
    end
  end

  assign irq = |(istat_r & imask_r);

  // ----------------------------------------
  // Read port
  // ----------------------------------------
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rdata <= 8'h00;
    end
    else if (bus.rd)
    begin
      case (bus.addr)
        RTCIC_CTRL_OFS: rdata <= {cselR, updateIrqEnable, timerIrqEnable,
                                 alarmIrqEnable, eventIrqEnable, 1'b0, clockHalt}; // RL13
        RTCIC_FLAG_OFS: rdata <= {2'h0, flag_r, 2'h0};
        RTCIC_ISTAT_OFS: rdata <= {4'h0, istat_r};
        RTCIC_IMASK_OFS: rdata <= {4'h0, imask_r};
        default: rdata <= 8'h00;
      endcase
    end
    else
    begin
      rdata <= 8'h00;
    end
  end

endmodule
`default_nettype wire

/* dv/rtcic_checker.sv */
// Port-level assertions of the interrupt control block
`timescale 1ns/10ps
`default_nettype none
module rtcic_checker
  import rtcic_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire rtcic_bus_t bus,
  input wire logic [7:0] rdata,
  input wire rtcic_evt_t evt,
  input wire logic chipEnable,
  input wire logic intPinO,
  input wire logic intPinOeN,
  input wire logic [1:0] compIntervalSel,
  input wire logic compTick,
  input wire logic subSecClear,
  input wire logic clockHalt,
  input wire logic irq
);
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic ctlWr;
  logic flagWr;
  // Same-cycle events are left out: their ordering against a write is the designer's choice
  assign ctlWr = bus.wr && bus.addr == RTCIC_CTRL_OFS && evt == 4'h0;
  assign flagWr = bus.wr && bus.addr == RTCIC_FLAG_OFS && evt == 4'h0;
  rdata_idle_a: assert property (!$past(bus.rd) |-> rdata == 8'h00)
    else $error("read data outside read slot");
  pin_data_a: assert property (intPinO == 1'b0)
    else $error("pin data not low");
  csel_write_a: assert property (ctlWr |=> compIntervalSel == $past(bus.wdata[7:6]))
    else $error("interval field not taken");
  halt_set_a: assert property (ctlWr && bus.wdata[0] |=> clockHalt && subSecClear)
    else $error("halt not entered");
  halt_release_a: assert property ((!chipEnable && !bus.wr) [*4] |-> !clockHalt)
    else $error("halt not released");
  enable_cancel_a: assert property (ctlWr && bus.wdata[5:2] == 4'h0 |-> ##2 intPinOeN)
    else $error("pin still driven after enables cleared");
  flag_release_a: assert property (flagWr && bus.wdata[5:2] == 4'h0 |=> intPinOeN)
    else $error("pin still driven after flags cleared");
  pin_cause_a: assert property ($fell(intPinOeN) |-> $past(evt) != 4'h0)
    else $error("pin driven without event");
  tick_pulse_a: assert property (compTick |=> !compTick)
    else $error("tick longer than one cycle");
  irq_cause_a: assert property ($rose(irq) |-> $past(evt) != 4'h0 || $past(bus.wr))
    else $error("irq rose without cause");
endmodule
`default_nettype wire

/* dv/rtcic_host_model.sv */
// Host side of the shared interrupt line with its pull-up
`timescale 1ns/10ps
`default_nettype none
module rtcic_host_model
(
  input wire logic intPinO,
  input wire logic intPinOeN,
  output logic intLevel
);
  // Pull-up holds the line high whenever the device lets go
  assign intLevel = intPinOeN ? 1'b1 : intPinO;
endmodule
`default_nettype wire

/* dv/rtc_interrupt_control_test.sv */
// Self-checking bench of the interrupt control block
`timescale 1ns/10ps
`default_nettype none
module rtc_interrupt_control_test
  import rtcic_pkg::*;
;
  localparam logic [19:0] REL = 20'h14;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  rtcic_bus_t bus = '0;
  rtcic_evt_t evtV = '0;
  logic chipEnable = 1'b1;
  logic [7:0] rdata;
  logic intPinO, intPinOeN, compTick, subSecClear, clockHalt, irq, intLevel;
  logic [1:0] compIntervalSel;
  logic [31:0] seed = 32'hDE1E;
  int errCount = 0;
  int totalChecks = 0;
  int cyc = 0;
  int n;
  always #4 clk = ~clk;
  rtcic_top #(.RELEASE_CYC(REL), .COMP0_CYC(32'h32), .COMP1_CYC(32'hC8), .COMP2_CYC(32'h3E8),
    .COMP3_CYC(32'hBB8)) uut (.clk(clk), .rst_n(rst_n), .bus(bus), .rdata(rdata), .evt(evtV),
    .chipEnable(chipEnable), .intPinO(intPinO), .intPinOeN(intPinOeN),
    .compIntervalSel(compIntervalSel), .compTick(compTick), .subSecClear(subSecClear),
    .clockHalt(clockHalt), .irq(irq));
  rtcic_host_model host (.intPinO(intPinO), .intPinOeN(intPinOeN), .intLevel(intLevel));
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction
  function automatic int period(input int s);
    return s == 0 ? 50 : s == 1 ? 200 : s == 2 ? 1000 : 3000;
  endfunction
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    totalChecks++;
    if (seen !== exp)
    begin
      errCount++;
      $display("ERROR %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    bus <= '{a, d, 1'b1, 1'b0};
    @(posedge clk);
    bus <= '0;
    #1;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
    @(posedge clk);
    bus <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge clk);
    bus <= '0;
    #1;
    chk(what, rdata, exp);
  endtask
  task automatic ev(input logic [3:0] e);
    @(posedge clk);
    evtV <= e;
    @(posedge clk);
    evtV <= '0;
    #1;
  endtask
  // Bounded so a stuck pin cannot hang the run
  task automatic lowLen(input int cap, output int k);
    k = 0;
    while (intLevel === 1'b0 && k < cap)
    begin
      k++;
      @(posedge clk);
      #1;
    end
  endtask
  // First gap may straddle an interval change, so the second one is kept
  task automatic tickGap(output int k);
    repeat (2)
    begin
      k = 0;
      do
      begin
        @(posedge clk);
        #1;
        k++;
      end
      while (compTick !== 1'b1 && k < 8000);
    end
  endtask
  task automatic summarize();
    $display("checks %0d errors %0d", totalChecks, errCount);
    if (errCount == 0 && totalChecks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 60000)
    begin
      errCount++;
      summarize();
    end
  end
  initial
  begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    rd(RTCIC_CTRL_OFS, 8'h40, "ctrl");
    chk("csel", compIntervalSel, 32'h1);
    for (int s = 0; s < 4; s++)
    begin
      wr(RTCIC_CTRL_OFS, 8'(s << 6));
      tickGap(n);
      chk("csel", compIntervalSel, 32'(s));
      chk("tickGap", n, period(s));
    end
    for (int i = 0; i < 4; i++)
    begin
      wr(RTCIC_CTRL_OFS, 8'h40 | 8'(4 << i));
      ev(4'(1 << i));
      chk("pinLow", intLevel, 32'h0);
      lowLen(100, n);
      chk("lowLen", n, i >= 2 ? 32'(REL) : 32'h64);
      wr(RTCIC_FLAG_OFS, 8'h00);
      chk("flagRel", intLevel, 32'h1);
      ev(4'(1 << i));
      wr(RTCIC_CTRL_OFS, 8'h40);
      // Cleared enable acts from the register, one edge after the write
      @(posedge clk);
      #1;
      chk("cancel", intLevel, 32'h1);
      wr(RTCIC_FLAG_OFS, 8'h00);
      ev(4'(1 << i));
      chk("quiet", intLevel, 32'h1);
      rd(RTCIC_FLAG_OFS, 8'(4 << i), "flag");
      wr(RTCIC_FLAG_OFS, 8'h00);
    end
    rd(8'h55, 8'h00, "unmapped");
    wr(RTCIC_ISTAT_OFS, 8'h0F);
    for (int k = 0; k < 12; k++)
    begin
      seed = xs(seed);
      wr(RTCIC_IMASK_OFS, {4'h0, seed[3:0]});
      wr(RTCIC_CTRL_OFS, {2'b01, seed[7:4], 2'b00});
      ev(seed[11:8]);
      chk("irq", irq, 32'(|(seed[3:0] & seed[11:8])));
      chk("pin", intLevel, 32'(~|(seed[7:4] & seed[11:8])));
      rd(RTCIC_ISTAT_OFS, {4'h0, seed[11:8]}, "istat");
      wr(RTCIC_ISTAT_OFS, 8'h0F);
      chk("irqClr", irq, 32'h0);
      wr(RTCIC_FLAG_OFS, 8'h00);
    end
    wr(RTCIC_CTRL_OFS, 8'h41);
    chk("halt", {clockHalt, subSecClear}, 32'h3);
    rd(RTCIC_CTRL_OFS, 8'h41, "ctrl");
    @(posedge clk);
    chipEnable <= 1'b0;
    repeat (4) @(posedge clk);
    #1;
    chk("run", {clockHalt, subSecClear}, 32'h0);
    rd(RTCIC_CTRL_OFS, 8'h40, "ctrl");
    chipEnable <= 1'b1;
    summarize();
  end
endmodule
bind rtcic_top rtcic_checker chk_i (.clk(clk), .rst_n(rst_n), .bus(bus), .rdata(rdata),
  .evt(evt), .chipEnable(chipEnable), .intPinO(intPinO), .intPinOeN(intPinOeN),
  .compIntervalSel(compIntervalSel), .compTick(compTick), .subSecClear(subSecClear),
  .clockHalt(clockHalt), .irq(irq));
`default_nettype wire
